// ---- hw/rc_arbiter_pkg.sv ----
// Package: shared types and constants for the remote control arbiter and link watchdog
package rc_arbiter_pkg;

    // Owner encoding of remote control
    typedef enum logic [2:0] {
        OWN_LOCAL  = 3'h0,
        OWN_REAR   = 3'h1,
        OWN_FRONT  = 3'h2,
        OWN_ANALOG = 3'h3,
        OWN_FIELD  = 3'h4,
        OWN_MASTER = 3'h5
    } owner_type;

    // Number of user interfaces (rear, front, analog, fieldbus)
    localparam int unsigned NUM_IF = 4;

    // Widths
    localparam int unsigned TMO_W = 32;
    localparam int unsigned ETH_W = 32;

    // Reset values
    localparam logic [TMO_W-1:0] TMO_RESET = 32'h0001_E848;   // 1 ms at 125 MHz
    localparam logic [ETH_W-1:0] ETH_RESET = 32'h0001_E848;

    // Link supervision: heartbeat must be seen within this many cycles
    localparam int unsigned LINK_TIME_US = 10;
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned LINK_CYCLES  = LINK_TIME_US * CLK_MHZ;

    // Per-interface request from a user interface
    typedef struct packed {
        logic takeReq;    // Request to take remote control
        logic leaveReq;   // Request to give control back
        logic msgValid;   // Any message received on this interface
        logic writeCmd;   // Message is a write/setting command
        logic outOnCmd;   // Write: switch output on
        logic outOffCmd;  // Write: switch output off
    } if_req_type;

    // Per-interface answer to a user interface
    typedef struct packed {
        logic granted;    // Request accepted
        logic refused;    // Request refused, error reported
        logic readAck;    // Read/status query served
        logic writeAck;   // Write carried out
    } if_rsp_type;

    // Configuration held by the device
    typedef struct packed {
        logic             monEnable;      // Interface monitoring on
        logic             keepOnAfterRem; // Output state after monitoring expiry: 1 keeps on
        logic             isSlave;        // Unit configured as slave
        logic [TMO_W-1:0] monTimeout;     // Monitoring timeout in cycles
        logic             ethEnable;      // Ethernet connection timeout on
        logic [ETH_W-1:0] ethTimeout;     // Ethernet timeout in cycles
    } cfg_type;

    // Request from master over master-slave link
    typedef struct packed {
        logic initReq;    // Master initializes slave
        logic releaseReq; // Master releases slave
        logic heartbeat;  // Link alive pulse
        logic outOnCmd;   // Master switches output on
        logic outOffCmd;  // Master switches output off
    } ms_req_type;

endpackage

// ---- hw/timeout_counter.sv ----
// Module: reloadable down counter with deferred reload value
`timescale 1ns/10ps
`default_nettype none
module timeout_counter #(
    parameter int unsigned W = 32
) (
    input  wire logic         ref_clk,   // System clock
    input  wire logic         rst_n,     // Sync reset, active low
    input  wire logic         clkEn,     // Clock enable
    input  wire logic         run,       // Counter enabled
    input  wire logic         restart,   // Restart period
    input  wire logic [W-1:0] loadVal,   // Period value, latched at period start
    output logic              expired    // One-cycle pulse at expiry
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         exp;
        logic         act;
    } st_type;

    st_type st_q;
    st_type st_d;

    // Next state: period value sampled only when a period starts
    always_comb begin
        st_d     = st_q;
        st_d.exp = 1'b0;
        if (!run) begin
            st_d.act = 1'b0;
        end else if (restart || !st_q.act) begin
            st_d.act = 1'b1;
            st_d.cnt = (loadVal == '0) ? W'(1) : loadVal;
        end else if (st_q.cnt == W'(1)) begin
            st_d.exp = 1'b1;
            st_d.act = 1'b0;
        end else begin
            st_d.cnt = st_q.cnt - W'(1);
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    assign expired = st_q.exp;
endmodule
`default_nettype wire

// ---- hw/remote_control_arbiter.sv ----
// Module: remote control arbiter and interface monitoring watchdog
`timescale 1ns/10ps
`default_nettype none
module remote_control_arbiter (
    input  wire logic                                ref_clk,      // System clock 125 MHz
    input  wire logic                                rst_n,        // Sync reset, active low
    input  wire logic                                clkEn,        // Clock enable
    input  wire logic                                buttonPin,    // Front pushbutton, async, high pressed
    input  wire logic                                alarmPending, // Device alarm shown on error LED
    input  wire rc_arbiter_pkg::cfg_type             cfg,          // Configuration
    input  wire rc_arbiter_pkg::if_req_type [3:0]    ifReq,        // Interface requests
    input  wire logic                                frontCmdOk,   // Front command within subset
    input  wire logic                                msActive,     // Master-slave operation running
    input  wire rc_arbiter_pkg::ms_req_type          msReq,        // Master link requests
    input  wire logic                                ethMsg,       // Ethernet message seen
    output rc_arbiter_pkg::if_rsp_type [3:0]         ifRsp,        // Interface answers
    output logic                                     msInitRefused,// Master init refused pulse
    output rc_arbiter_pkg::owner_type                owner,        // Current owner
    output logic                                     outputOn,     // Output stage on
    output logic                                     alarmAck,     // Alarm acknowledge pulse
    output logic                                     ms_link_protection_alarm, // Link protection alarm
    output logic                                     monExpired,   // Monitoring expiry pulse
    output logic                                     ethExpired    // Ethernet timeout pulse
);
    localparam int unsigned FRONT_IDX = 1;

    typedef struct packed {
        logic [2:0]                     btnSync;
        logic                           btnState;
        rc_arbiter_pkg::owner_type      own;
        logic                           outOn;
        logic                           ack;
        logic                           linkAlarm;
        logic [15:0]                    linkCnt;
        logic                           msInitRef;
        rc_arbiter_pkg::if_rsp_type [3:0] rsp;
        logic                           monExp;
        logic                           ethExp;
    } st_type;

    st_type st_q;
    st_type st_d;

    logic monRun;
    logic monRestart;
    logic monTick;
    logic ethTick;

    // ==================================================================
    // Timers
    // ==================================================================
    // Watched owner message restarts the period
    always_comb begin
        monRestart = 1'b0;
        for (int i = 0; i < rc_arbiter_pkg::NUM_IF; i++) begin
            if (st_q.own == rc_arbiter_pkg::owner_type'(i + 1) && ifReq[i].msgValid) begin
                monRestart = 1'b1;
            end
        end
    end

    // owner only, never on a slave
    assign monRun = cfg.monEnable && !cfg.isSlave
                    && st_q.own != rc_arbiter_pkg::OWN_LOCAL
                    && st_q.own != rc_arbiter_pkg::OWN_MASTER;

    timeout_counter #(.W(rc_arbiter_pkg::TMO_W)) monTimer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .run     (monRun),
        .restart (monRestart),
        .loadVal (cfg.monTimeout),
        .expired (monTick)
    );

    timeout_counter #(.W(rc_arbiter_pkg::ETH_W)) ethTimer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .run     (cfg.ethEnable),
        .restart (ethMsg),
        .loadVal (cfg.ethTimeout),
        .expired (ethTick)
    );

    // ==================================================================
    // Arbitration and output control
    // ==================================================================
    always_comb begin
        logic btnPress;
        logic anyRemote;
        btnPress  = 1'b0;
        anyRemote = 1'b0;
        st_d      = st_q;
        st_d.ack       = 1'b0;
        st_d.msInitRef = 1'b0;
        st_d.monExp    = monTick;
        st_d.ethExp    = ethTick;
        st_d.rsp       = '0;

        // Three-stage button sync, change once stages two and three agree
        st_d.btnSync = {st_q.btnSync[1:0], buttonPin};
        if (st_q.btnSync[2] == st_q.btnSync[1] && st_q.btnSync[2] != st_q.btnState) begin
            st_d.btnState = st_q.btnSync[2];
            btnPress      = st_q.btnSync[2];
        end
        anyRemote = st_q.own != rc_arbiter_pkg::OWN_LOCAL;

        if (btnPress && alarmPending) begin
            st_d.ack = 1'b1;
        end
        if (btnPress && !cfg.isSlave && !anyRemote) begin
            st_d.outOn = !st_q.outOn;
        end

        // Master link requests
        if (msReq.initReq) begin
            if (st_q.own == rc_arbiter_pkg::OWN_REAR || st_q.own == rc_arbiter_pkg::OWN_FRONT) begin
                st_d.msInitRef = 1'b1;
            end else if (!anyRemote) begin
                st_d.own = rc_arbiter_pkg::OWN_MASTER;
            end else begin
                st_d.msInitRef = 1'b1;
            end
        end
        if (msReq.releaseReq && st_q.own == rc_arbiter_pkg::OWN_MASTER) begin
            st_d.own = rc_arbiter_pkg::OWN_LOCAL;
        end
        if (st_q.own == rc_arbiter_pkg::OWN_MASTER) begin
            if (msReq.outOnCmd) begin
                st_d.outOn = 1'b1;
            end
            if (msReq.outOffCmd) begin
                st_d.outOn = 1'b0;
            end
        end

        // Interface requests, lowest index wins a tie
        for (int i = 0; i < rc_arbiter_pkg::NUM_IF; i++) begin
            if (ifReq[i].takeReq) begin
                if (msActive || st_q.own == rc_arbiter_pkg::OWN_MASTER) begin
                    st_d.rsp[i].refused = 1'b1;
                end else if (st_d.own == rc_arbiter_pkg::OWN_LOCAL
                             || st_d.own == rc_arbiter_pkg::owner_type'(i + 1)) begin
                    st_d.own = rc_arbiter_pkg::owner_type'(i + 1);
                    st_d.rsp[i].granted = 1'b1;
                end else begin
                    st_d.rsp[i].refused = 1'b1;
                end
            end
            if (ifReq[i].leaveReq && st_q.own == rc_arbiter_pkg::owner_type'(i + 1)) begin
                st_d.own = rc_arbiter_pkg::OWN_LOCAL;
            end
            if (ifReq[i].msgValid && !ifReq[i].writeCmd) begin
                st_d.rsp[i].readAck = (i != FRONT_IDX) || frontCmdOk;
                st_d.rsp[i].refused = st_d.rsp[i].refused || ((i == FRONT_IDX) && !frontCmdOk);
            end
            if (ifReq[i].msgValid && ifReq[i].writeCmd) begin
                if (i == FRONT_IDX && (!frontCmdOk || (anyRemote
                        && st_q.own != rc_arbiter_pkg::OWN_FRONT))) begin
                    st_d.rsp[i].refused = 1'b1;
                end else if (i != FRONT_IDX && st_q.own != rc_arbiter_pkg::owner_type'(i + 1)) begin
                    st_d.rsp[i].refused = 1'b1;
                end else begin
                    st_d.rsp[i].writeAck = 1'b1;
                    if (ifReq[i].outOnCmd) begin
                        st_d.outOn = 1'b1;
                    end
                    if (ifReq[i].outOffCmd) begin
                        st_d.outOn = 1'b0;
                    end
                end
            end
        end

        if (monTick && monRun) begin
            st_d.own = rc_arbiter_pkg::OWN_LOCAL;
            if (!cfg.keepOnAfterRem) begin
                st_d.outOn = 1'b0;
            end
        end

        if (!msActive || msReq.heartbeat) begin
            st_d.linkCnt = '0;
        end else if (st_q.linkCnt >= 16'(rc_arbiter_pkg::LINK_CYCLES)) begin
            st_d.linkAlarm = 1'b1;
        end else begin
            st_d.linkCnt = st_q.linkCnt + 16'h0001;
        end
        if (btnPress && st_q.linkAlarm && msReq.heartbeat) begin
            st_d.linkAlarm = 1'b0;
        end
        if (st_q.linkAlarm) begin
            st_d.outOn = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    // Registered outputs
    assign ifRsp                    = st_q.rsp;
    assign msInitRefused            = st_q.msInitRef;
    assign owner                    = st_q.own;
    assign outputOn                 = st_q.outOn;
    assign alarmAck                 = st_q.ack;
    assign ms_link_protection_alarm = st_q.linkAlarm;
    assign monExpired               = st_q.monExp;
    assign ethExpired               = st_q.ethExp;
endmodule
`default_nettype wire

// ---- verif/rc_arbiter_monitor.sv ----
// Checker: port-level assertions for the remote control arbiter
`timescale 1ns/10ps
`default_nettype none
module rc_arbiter_monitor (
    input wire logic                             ref_clk,  // Clock
    input wire logic                             rst_n,    // Reset, active low
    input wire logic                             clkEn,    // Clock enable
    input wire rc_arbiter_pkg::cfg_type          cfg,      // Configuration
    input wire rc_arbiter_pkg::if_req_type [3:0] ifReq,    // Interface requests
    input wire logic                             frontCmdOk, // Front command within subset
    input wire logic                             msActive, // Master-slave running
    input wire rc_arbiter_pkg::ms_req_type       msReq,    // Master requests
    input wire rc_arbiter_pkg::if_rsp_type [3:0] ifRsp,    // Interface answers
    input wire logic                             msInitRefused, // Init refused
    input wire rc_arbiter_pkg::owner_type        owner,    // Current owner
    input wire logic                             outputOn, // Output stage
    input wire logic                             ms_link_protection_alarm, // Link alarm
    input wire logic                             monExpired // Expiry pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Sequences
    sequence s_take_in_ms;
        clkEn && msActive && ifReq[0].takeReq;
    endsequence
    sequence s_front_write_foreign;
        clkEn && ifReq[1].msgValid && ifReq[1].writeCmd && owner inside {rc_arbiter_pkg::OWN_REAR,
            rc_arbiter_pkg::OWN_ANALOG, rc_arbiter_pkg::OWN_FIELD, rc_arbiter_pkg::OWN_MASTER};
    endsequence
    // ==========================================
    // Properties
    property p_grant_owner;
        ifRsp[0].granted |-> owner == rc_arbiter_pkg::OWN_REAR;
    endproperty
    property p_ms_refuse;
        s_take_in_ms |=> ifRsp[0].refused && !ifRsp[0].granted;
    endproperty
    property p_init_refuse;
        clkEn && msReq.initReq && owner inside {rc_arbiter_pkg::OWN_REAR, rc_arbiter_pkg::OWN_FRONT}
            |=> msInitRefused && owner != rc_arbiter_pkg::OWN_MASTER;
    endproperty
    property p_front_read;
        clkEn && ifReq[1].msgValid && !ifReq[1].writeCmd && frontCmdOk |=> ifRsp[1].readAck;
    endproperty
    property p_front_write;
        s_front_write_foreign |=> !ifRsp[1].writeAck;
    endproperty
    property p_exp_local;
        monExpired |-> owner == rc_arbiter_pkg::OWN_LOCAL;
    endproperty
    property p_exp_off;
        monExpired && !cfg.keepOnAfterRem |-> !outputOn;
    endproperty
    property p_mon_off;
        (!cfg.monEnable)[*3] |-> !monExpired;
    endproperty
    property p_slave_idle;
        (cfg.isSlave)[*3] |-> !monExpired;
    endproperty
    property p_alarm_off;
        ms_link_protection_alarm[*2] |-> !outputOn;
    endproperty
    a_grant_owner: assert property (p_grant_owner) else $error("grant without owner");
    a_ms_refuse: assert property (p_ms_refuse) else $error("take in master-slave not refused");
    a_init_refuse: assert property (p_init_refuse) else $error("master init not refused");
    a_front_read: assert property (p_front_read) else $error("front read not served");
    a_front_write: assert property (p_front_write) else $error("foreign front write done");
    a_exp_local: assert property (p_exp_local) else $error("expiry kept remote");
    a_exp_off: assert property (p_exp_off) else $error("expiry kept output on");
    a_mon_off: assert property (p_mon_off) else $error("expiry while disabled");
    a_slave_idle: assert property (p_slave_idle) else $error("expiry on slave");
    a_alarm_off: assert property (p_alarm_off) else $error("output on under alarm");
endmodule
bind remote_control_arbiter rc_arbiter_monitor mon_u (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .cfg(cfg), .ifReq(ifReq), .frontCmdOk(frontCmdOk), .msActive(msActive), .msReq(msReq), .ifRsp(ifRsp),
    .msInitRefused(msInitRefused), .owner(owner), .outputOn(outputOn),
    .ms_link_protection_alarm(ms_link_protection_alarm), .monExpired(monExpired));
`default_nettype wire

// ---- verif/host_link_model.sv ----
// Model: host messages and master link heartbeats
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
    input  wire logic       ref_clk, // Clock
    input  wire logic       rst_n,   // Reset, active low
    input  wire logic       hbEn,    // Send heartbeats
    input  wire logic       msgEn,   // Send messages
    output logic            hb,      // Heartbeat pulse
    output logic            msg      // Message pulse
);
    int hbCnt = 0;
    int msgCnt = 0;
    // Pulses launched on the falling edge
    always @(negedge ref_clk) begin
        hbCnt <= (hbCnt == 99) ? 0 : hbCnt + 1;
        msgCnt <= (msgCnt == 7) ? 0 : msgCnt + 1;
        hb <= rst_n && hbEn && hbCnt == 0;
        msg <= rst_n && msgEn && msgCnt == 0;
    end
endmodule
`default_nettype wire

// ---- verif/remote_control_arbiter_bench.sv ----
// Testbench: remote control arbiter and watchdog
`timescale 1ns/10ps
`default_nettype none
module remote_control_arbiter_bench;
    localparam logic [5:0] TAKE = 6'h20, LEAVE = 6'h10, READ = 6'h08, WRON = 6'h0E, WROFF = 6'h0D;
    logic ref_clk = 1'b0, rst_n = 1'b0, buttonPin = 1'b0, alarmPending = 1'b0;
    logic msActive = 1'b0, ethMsg = 1'b0, frontCmdOk = 1'b1, hbEn = 1'b1, msgEn = 1'b0;
    logic clkEn = 1'b1;
    logic hb, msg, msInitRefused, outputOn, alarmAck, linkAlarm, monExpired, ethExpired;
    rc_arbiter_pkg::cfg_type cfg = '0;
    rc_arbiter_pkg::if_req_type [3:0] ifReq = '0, ifReqW;
    rc_arbiter_pkg::ms_req_type msReq = '0, msReqW;
    rc_arbiter_pkg::if_rsp_type [3:0] ifRsp;
    rc_arbiter_pkg::if_rsp_type rspSeen;
    rc_arbiter_pkg::owner_type owner;
    int err_total = 0, compares = 0, cycles = 0, m, e;
    // Clock and hang guard
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end
    // Merge model pulses into requests
    always_comb begin
        ifReqW = ifReq;
        ifReqW[0].msgValid = ifReq[0].msgValid | msg;
        msReqW = msReq;
        msReqW.heartbeat = hb;
    end
    remote_control_arbiter dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .buttonPin(buttonPin),
        .alarmPending(alarmPending), .cfg(cfg), .ifReq(ifReqW), .frontCmdOk(frontCmdOk),
        .msActive(msActive), .msReq(msReqW), .ethMsg(ethMsg), .ifRsp(ifRsp), .msInitRefused(msInitRefused),
        .owner(owner), .outputOn(outputOn), .alarmAck(alarmAck), .ms_link_protection_alarm(linkAlarm),
        .monExpired(monExpired), .ethExpired(ethExpired));
    host_link_model host_u (.ref_clk(ref_clk), .rst_n(rst_n), .hbEn(hbEn), .msgEn(msgEn), .hb(hb), .msg(msg));
    // ==========================================
    // Helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // One-cycle request, answer caught while it stands, then an idle cycle
    task automatic ifPulse(input int i, input logic [5:0] f);
        ifReq[i] = f;
        tick(1);
        rspSeen = ifRsp[i];
        ifReq[i] = '0;
        tick(1);
    endtask
    task automatic watch(input int n);
        m = 0;
        e = 0;
        repeat (n) begin
            tick(1);
            m += int'(monExpired === 1'b1);
            e += int'(ethExpired === 1'b1);
        end
    endtask
    task automatic press();
        buttonPin = 1'b1;
        watch(8);
        buttonPin = 1'b0;
        tick(6);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_owner();
        ifPulse(0, TAKE);
        chk("rear take", 4'h8, rspSeen);
        ifPulse(1, TAKE);
        chk("front take", 4'h4, rspSeen);
        ifPulse(1, READ);
        chk("front read", 4'h2, rspSeen);
        ifPulse(1, WRON);
        chk("front write", 4'h4, rspSeen);
        msReq.initReq = 1'b1;
        tick(1);
        msReq = '0;
        chk("init refused", 1, msInitRefused);
        chk("owner kept", rc_arbiter_pkg::OWN_REAR, owner);
        ifPulse(0, WRON);
        chk("rear write", 4'h1, rspSeen);
        ifPulse(0, LEAVE);
        ifPulse(1, WROFF);
        chk("local front write", 4'h1, rspSeen);
        chk("output off", 0, outputOn);
        // Front messages outside the reduced subset are refused
        frontCmdOk = 1'b0;
        ifPulse(1, READ);
        chk("front read outside subset", 4'h4, rspSeen);
        ifPulse(1, WRON);
        chk("front write outside subset", 4'h4, rspSeen);
        chk("output unchanged", 0, outputOn);
        frontCmdOk = 1'b1;
    endtask
    task automatic t_ms();
        msActive = 1'b1;
        ifPulse(0, TAKE);
        chk("take in ms", 4'h4, rspSeen);
        chk("owner local", rc_arbiter_pkg::OWN_LOCAL, owner);
        msActive = 1'b0;
    endtask
    task automatic t_timeout();
        cfg.monEnable = 1'b1;
        cfg.monTimeout = 32'h0000_003C;
        cfg.ethEnable = 1'b1;
        cfg.ethTimeout = 32'h0000_001E;
        ifPulse(0, TAKE);
        ifPulse(0, WRON);
        msgEn = 1'b1;
        watch(100);
        chk("no expiry", 0, m);
        chk("eth expiry", 1, e > 0);
        msgEn = 1'b0;
        // Let a message already launched land before the period changes
        tick(1);
        cfg.monTimeout = 32'h0000_0005;
        watch(40);
        chk("old period kept", 0, m);
        watch(40);
        chk("expiry", 1, m);
        chk("owner local", rc_arbiter_pkg::OWN_LOCAL, owner);
        chk("output off", 0, outputOn);
        cfg.keepOnAfterRem = 1'b1;
        cfg.monTimeout = 32'h0000_0014;
        ifPulse(0, TAKE);
        ifPulse(0, WRON);
        watch(40);
        chk("keep expiry", 1, m);
        chk("output kept", 1, outputOn);
    endtask
    task automatic t_mon_off();
        cfg.monEnable = 1'b0;
        ifPulse(0, TAKE);
        watch(100);
        chk("no expiry", 0, m);
        chk("owner held", rc_arbiter_pkg::OWN_REAR, owner);
        // Clock enable low freezes ownership against a leave request
        clkEn = 1'b0;
        ifPulse(0, LEAVE);
        chk("frozen owner", rc_arbiter_pkg::OWN_REAR, owner);
        clkEn = 1'b1;
    endtask
    task automatic t_button();
        alarmPending = 1'b1;
        press();
        chk("owned no toggle", 1, outputOn);
        ifPulse(0, LEAVE);
        buttonPin = 1'b1;
        m = 0;
        repeat (8) begin
            tick(1);
            m += int'(alarmAck === 1'b1);
        end
        buttonPin = 1'b0;
        tick(6);
        chk("alarm ack", 1, m);
        chk("toggle off", 0, outputOn);
        cfg.isSlave = 1'b1;
        press();
        chk("slave no toggle", 0, outputOn);
        cfg.isSlave = 1'b0;
        press();
        chk("toggle on", 1, outputOn);
    endtask
    task automatic t_link();
        hbEn = 1'b0;
        msActive = 1'b1;
        tick(1400);
        chk("link alarm", 1, linkAlarm);
        chk("alarm output", 0, outputOn);
        hbEn = 1'b1;
        msActive = 1'b0;
    endtask
    task automatic final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(4);
        rst_n = 1'b1;
        tick(1);
        t_owner();
        t_ms();
        t_timeout();
        t_mon_off();
        t_button();
        t_link();
        final_report();
    end
endmodule
`default_nettype wire
